// file: core/addr_map_pkg.sv
// address map constants, window table and target codes for the system address decoder
// assumes one 250 MHz clock shared by both bus masters and the decoder
package addr_map_pkg;

  typedef enum logic [3:0] {
    TGT_NONE, TGT_FLASH, TGT_SUPERVISORY_ROM, TGT_SRAM, TGT_CPU_SUBSYSTEM,
    TGT_IO_ROUTING_MATRIX, TGT_CLOCKS, TGT_IO_PORT, TGT_TIMER, TGT_SERIAL,
    TGT_TOUCH, TGT_LCD, TGT_COMPARATOR, TGT_POWER_CONTROL, TGT_CORE_PRIVATE_BUS
  } target_t;

  localparam int NWIN = 14;
  localparam int VECTOR_SRAM_BIT = 0;
  localparam logic [31:0] ADDR_ZERO = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_REGION_LAST = 32'h3FFF_FFFF;
  localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
  localparam logic [31:0] PERIPH_LAST = 32'h5FFF_FFFF;
  localparam logic [31:0] UNUSED_BASE = 32'h6000_0000;
  localparam logic [31:0] UNUSED_LAST = 32'hDFFF_FFFF;
  localparam logic [31:0] PRIVATE_BASE = 32'hE000_0000;
  localparam logic [31:0] PRIVATE_LAST = 32'hE00F_FFFF;
  localparam logic [31:0] FLASH_LAST = 32'h0000_7FFF;
  localparam logic [31:0] SUPV_BASE = 32'h1000_0000;
  localparam logic [31:0] SUPV_LAST = 32'h1000_0FFF;
  localparam logic [31:0] SRAM_LAST = 32'h2000_0FFF;
  localparam logic [31:0] IOMX_BASE = 32'h4001_0000;
  localparam logic [31:0] IOMX_LAST = 32'h4001_0FFF;
  localparam logic [31:0] COMP_BASE = 32'h400A_0000;
  localparam logic [31:0] COMP_LAST = 32'h400A_FFFF;

  // window order follows target_t after TGT_NONE
  localparam logic [31:0] WIN_BASE [NWIN] = '{
    ADDR_ZERO, SUPV_BASE, SRAM_BASE, PERIPH_BASE, IOMX_BASE, 32'h4002_0000,
    32'h4004_0000, 32'h4005_0000, 32'h4006_0000, 32'h4008_0000, 32'h4009_0000,
    COMP_BASE, 32'h400B_0000, PRIVATE_BASE
  };
  localparam logic [31:0] WIN_LAST [NWIN] = '{
    FLASH_LAST, SUPV_LAST, SRAM_LAST, 32'h4000_FFFF, IOMX_LAST, 32'h4002_FFFF,
    32'h4004_FFFF, 32'h4005_FFFF, 32'h4006_FFFF, 32'h4008_FFFF, 32'h4009_FFFF,
    COMP_LAST, 32'h400B_FFFF, PRIVATE_LAST
  };
  // only flash, supervisory rom and sram may be fetched from
  localparam logic [NWIN-1:0] WIN_EXEC = 14'h0007;

  localparam logic MASTER_CPU = 1'h0;
  localparam logic MASTER_DEBUG = 1'h1;

endpackage

// file: core/window_match.sv
// address window comparator bank for the system address decoder
// assumes a stable address from the arbitration stage in the same cycle
module window_match (
  input wire logic [31:0] addr,
  output addr_map_pkg::target_t target,
  output logic execOk,
  output logic [31:0] winBase
);

  logic [addr_map_pkg::NWIN-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < addr_map_pkg::NWIN; i++) begin : g_win
      assign hit[i] = (addr >= addr_map_pkg::WIN_BASE[i]) &&
                      (addr <= addr_map_pkg::WIN_LAST[i]);
    end
  endgenerate

  // windows never overlap, so the lowest hit is the only one
  always_comb begin
    target = addr_map_pkg::TGT_NONE;
    execOk = 1'b0;
    winBase = addr_map_pkg::ADDR_ZERO;
    for (int k = addr_map_pkg::NWIN - 1; k >= 0; k--) begin
      if (hit[k]) begin
        target = addr_map_pkg::target_t'(4'(k + 1));
        execOk = addr_map_pkg::WIN_EXEC[k];
        winBase = addr_map_pkg::WIN_BASE[k];
      end
    end
  end

endmodule

// file: core/system_address_decoder.sv
// system address decoder: arbitrates two masters, decodes, answers one cycle later
// assumes both masters and the configuration word run on sys_clk
module system_address_decoder (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [31:0] cpuSubsystemConfig,
  input wire logic cpuReq,
  input wire logic [31:0] cpuAddr,
  input wire logic cpuWrite,
  input wire logic cpuFetch,
  input wire logic cpuVector,
  output logic cpuGnt,
  input wire logic dbgReq,
  input wire logic [31:0] dbgAddr,
  input wire logic dbgWrite,
  output logic dbgGnt,
  output logic respValid,
  output logic respMaster,
  output logic respWrite,
  output logic respErr,
  output addr_map_pkg::target_t respTarget,
  output logic [31:0] respOffset,
  output logic sysBusSel,
  output logic corePrivateSel
);

  typedef struct packed {
    logic valid;
    logic master;
    logic write;
    logic err;
    addr_map_pkg::target_t target;
    logic [31:0] offset;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic vectorTableInSram;
  logic take;
  logic selMaster;
  logic [31:0] selAddr;
  logic [31:0] decAddr;
  logic selWrite;
  logic selFetch;
  logic selVector;
  addr_map_pkg::target_t target;
  logic execOk;
  logic [31:0] winBase;

  assign vectorTableInSram = cpuSubsystemConfig[addr_map_pkg::VECTOR_SRAM_BIT];

  // processor first; debug gets any cycle the processor leaves idle
  assign cpuGnt = cpuReq;
  assign dbgGnt = dbgReq && !cpuReq;
  assign take = cpuReq || dbgReq;
  assign selMaster = cpuReq ? addr_map_pkg::MASTER_CPU : addr_map_pkg::MASTER_DEBUG;
  assign selAddr = cpuReq ? cpuAddr : dbgAddr;
  assign selWrite = cpuReq ? cpuWrite : dbgWrite;
  assign selFetch = cpuReq && cpuFetch;
  assign selVector = cpuReq && cpuVector;

  // vector offsets are relative to zero; an sram table sits at the sram base
  assign decAddr = (selVector && vectorTableInSram) ?
                   (addr_map_pkg::SRAM_BASE | selAddr) : selAddr;

  window_match u_match (
    .addr(decAddr),
    .target(target),
    .execOk(execOk),
    .winBase(winBase)
  );

  always_comb begin
    st_d = st_q;
    st_d.valid = take;
    st_d.master = selMaster;
    st_d.write = selWrite;
    st_d.target = target;
    st_d.offset = decAddr - winBase;
    // unmapped, or a fetch from a window without execute right
    st_d.err = take && ((target == addr_map_pkg::TGT_NONE) || (selFetch && !execOk));
    if (!take) begin
      st_d.target = addr_map_pkg::TGT_NONE;
      st_d.offset = addr_map_pkg::ADDR_ZERO;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign respValid = st_q.valid;
  assign respMaster = st_q.master;
  assign respWrite = st_q.write;
  assign respErr = st_q.err;
  assign respTarget = st_q.target;
  assign respOffset = st_q.offset;
  // private window never reaches the system interconnect
  assign corePrivateSel = st_q.valid && !st_q.err &&
                          (st_q.target == addr_map_pkg::TGT_CORE_PRIVATE_BUS);
  assign sysBusSel = st_q.valid && !st_q.err &&
                     (st_q.target != addr_map_pkg::TGT_CORE_PRIVATE_BUS);

  sequence cpuHit(logic [31:0] lo, logic [31:0] hi);
    cpuReq && cpuAddr >= lo && cpuAddr <= hi;
  endsequence

  sequence answer(addr_map_pkg::target_t t, logic e);
    respValid && respTarget == t && respErr == e;
  endsequence

  AST_VECT_SRAM: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuReq && cpuVector && vectorTableInSram &&
    (cpuAddr | addr_map_pkg::SRAM_BASE) <= addr_map_pkg::SRAM_LAST
    |=> answer(addr_map_pkg::TGT_SRAM, 1'b0)) else $error("vector not taken from sram");

  AST_VECT_FLASH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuReq && cpuVector && cpuAddr <= addr_map_pkg::FLASH_LAST && !vectorTableInSram
    ##1 answer(addr_map_pkg::TGT_FLASH, 1'b0) |-> respOffset == $past(cpuAddr))
    else $error("flash vector offset wrong");

  AST_CODE_FETCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuHit(addr_map_pkg::ADDR_ZERO, addr_map_pkg::FLASH_LAST) and cpuFetch and !cpuVector
    |=> answer(addr_map_pkg::TGT_FLASH, 1'b0)) else $error("code fetch refused");

  AST_SRAM_FETCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuHit(addr_map_pkg::SRAM_BASE, addr_map_pkg::SRAM_LAST) and !cpuVector
    |=> answer(addr_map_pkg::TGT_SRAM, 1'b0)) else $error("sram access refused");

  AST_PERIPH_NOEXEC: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuHit(addr_map_pkg::PERIPH_BASE, addr_map_pkg::PERIPH_LAST) and cpuFetch and !cpuVector
    |=> respValid && respErr && !sysBusSel) else $error("peripheral fetch allowed");

  AST_PRIVATE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuHit(addr_map_pkg::PRIVATE_BASE, addr_map_pkg::PRIVATE_LAST) and !cpuFetch and !cpuVector
    |=> corePrivateSel && !sysBusSel) else $error("private access left core");

  AST_SUPV: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuHit(addr_map_pkg::SUPV_BASE, addr_map_pkg::SUPV_LAST) and !cpuVector
    |=> answer(addr_map_pkg::TGT_SUPERVISORY_ROM, 1'b0)) else $error("supervisory miss");

  AST_IOMX: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuHit(addr_map_pkg::IOMX_BASE, addr_map_pkg::IOMX_LAST) and !cpuFetch and !cpuVector
    |=> answer(addr_map_pkg::TGT_IO_ROUTING_MATRIX, 1'b0)) else $error("routing matrix miss");

  AST_COMP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuHit(addr_map_pkg::COMP_BASE, addr_map_pkg::COMP_LAST) and !cpuFetch and !cpuVector
    |=> answer(addr_map_pkg::TGT_COMPARATOR, 1'b0)) else $error("comparator miss");

  AST_DEBUG: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dbgReq && !cpuReq |-> dbgGnt ##1 respValid && respMaster == addr_map_pkg::MASTER_DEBUG)
    else $error("debug request not served");

  AST_UNUSED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuHit(addr_map_pkg::UNUSED_BASE, addr_map_pkg::UNUSED_LAST) and !cpuVector
    |=> answer(addr_map_pkg::TGT_NONE, 1'b1)) else $error("unused space not erred");

  // every window, data side: target code and offset from its own base
  genvar w;
  generate
    for (w = 0; w < addr_map_pkg::NWIN; w++) begin : g_win_chk
      AST_WIN_DATA: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cpuHit(addr_map_pkg::WIN_BASE[w], addr_map_pkg::WIN_LAST[w])
        and !cpuFetch and !cpuVector
        |=> answer(addr_map_pkg::target_t'(4'(w + 1)), 1'b0) ##0
        respOffset == $past(cpuAddr) - addr_map_pkg::WIN_BASE[w])
        else $error("window data access misrouted");
    end
  endgenerate

  AST_FLASH_GAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuReq && !cpuVector && cpuAddr > addr_map_pkg::FLASH_LAST && cpuAddr < addr_map_pkg::SUPV_BASE
    |=> answer(addr_map_pkg::TGT_NONE, 1'b1)) else $error("flash gap not erred");

  AST_SUPV_GAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuReq && !cpuVector && cpuAddr > addr_map_pkg::SUPV_LAST && cpuAddr < addr_map_pkg::SRAM_BASE
    |=> answer(addr_map_pkg::TGT_NONE, 1'b1)) else $error("supervisory gap not erred");

  AST_SRAM_GAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuHit(addr_map_pkg::SRAM_LAST + 32'h1, addr_map_pkg::SRAM_REGION_LAST) and !cpuVector
    |=> answer(addr_map_pkg::TGT_NONE, 1'b1)) else $error("sram gap not erred");

  AST_DEVICE_GAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuReq && !cpuVector && cpuAddr > addr_map_pkg::PRIVATE_LAST
    |=> answer(addr_map_pkg::TGT_NONE, 1'b1)) else $error("device space not erred");

  AST_PRIVATE_FETCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuHit(addr_map_pkg::PRIVATE_BASE, addr_map_pkg::PRIVATE_LAST) and cpuFetch and !cpuVector
    |=> respValid && respErr && !corePrivateSel) else $error("private fetch allowed");

  AST_VECT_SRAM_OFFSET: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuReq && cpuVector && vectorTableInSram &&
    (cpuAddr | addr_map_pkg::SRAM_BASE) <= addr_map_pkg::SRAM_LAST
    ##1 answer(addr_map_pkg::TGT_SRAM, 1'b0)
    |-> respOffset == ($past(cpuAddr) | addr_map_pkg::SRAM_BASE) - addr_map_pkg::SRAM_BASE)
    else $error("sram vector offset wrong");

  AST_DEBUG_MAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dbgReq && !cpuReq && dbgAddr >= addr_map_pkg::SRAM_BASE && dbgAddr <= addr_map_pkg::SRAM_LAST
    |=> answer(addr_map_pkg::TGT_SRAM, 1'b0) ##0
    respOffset == $past(dbgAddr) - addr_map_pkg::SRAM_BASE) else $error("debug sram misrouted");

  AST_DEBUG_UNUSED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dbgReq && !cpuReq && dbgAddr >= addr_map_pkg::UNUSED_BASE && dbgAddr <= addr_map_pkg::UNUSED_LAST
    |=> answer(addr_map_pkg::TGT_NONE, 1'b1)) else $error("debug unused not erred");

  AST_CPU_FIRST: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpuReq |-> cpuGnt && !dbgGnt ##1 respValid && respMaster == addr_map_pkg::MASTER_CPU)
    else $error("processor not served first");

  AST_WRITE_COPY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    take |=> respWrite == $past(selWrite)) else $error("write bit lost");

  AST_TAKEN_ANSWERED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    take |=> respValid) else $error("request not answered");

  AST_ANSWER_TAKEN: assert property (@(posedge sys_clk) disable iff (sys_rst)
    respValid |-> $past(take)) else $error("answer without request");

  AST_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !take |=> !respValid && respTarget == addr_map_pkg::TGT_NONE && !sysBusSel && !corePrivateSel)
    else $error("idle cycle selected a target");

endmodule

// file: dv/debug_master.sv
// debug master model: posts one access and holds it until granted
// assumes the same sys_clk as the decoder
module debug_master (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [31:0] addr,
  output logic dbgReq,
  output logic [31:0] dbgAddr,
  output logic dbgWrite,
  input wire logic dbgGnt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    dbgReq = 1'h0;
    dbgAddr = 32'h0;
    dbgWrite = 1'h0;
  end
  // released address is inverted so a stale value never passes as live
  always @(posedge sys_clk) begin
    if (dbgReq && dbgGnt) begin
      dbgReq <= 1'h0;
      dbgAddr <= ~dbgAddr;
    end else if (go && !dbgReq) begin
      dbgReq <= 1'h1;
      dbgAddr <= addr;
    end
  end
endmodule

// file: dv/system_address_decoder_test.sv
// self-checking bench for the system address decoder
// assumes one 4 ns clock and the debug master model beside the dut
module system_address_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, sys_rst = 1'h1, cpuReq = 1'h0, cpuWrite = 1'h0;
  logic cpuFetch = 1'h0, cpuVector = 1'h0, go = 1'h0;
  logic [31:0] cfg = 32'h0, cpuAddr = 32'h0, goAddr = 32'h0;
  logic cpuGnt, dbgReq, dbgWrite, dbgGnt, respValid, respMaster, respWrite, respErr;
  logic sysBusSel, corePrivateSel;
  logic [31:0] dbgAddr, respOffset;
  addr_map_pkg::target_t respTarget;
  int fails = 0, compares = 0;

  system_address_decoder dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cpuSubsystemConfig(cfg), .cpuReq(cpuReq), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
    .cpuFetch(cpuFetch), .cpuVector(cpuVector), .cpuGnt(cpuGnt), .dbgReq(dbgReq),
    .dbgAddr(dbgAddr), .dbgWrite(dbgWrite), .dbgGnt(dbgGnt), .respValid(respValid),
    .respMaster(respMaster), .respWrite(respWrite), .respErr(respErr),
    .respTarget(respTarget), .respOffset(respOffset), .sysBusSel(sysBusSel),
    .corePrivateSel(corePrivateSel));
  debug_master master (.sys_clk(sys_clk), .go(go), .addr(goAddr), .dbgReq(dbgReq),
    .dbgAddr(dbgAddr), .dbgWrite(dbgWrite), .dbgGnt(dbgGnt));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (!ok) begin
      fails++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one processor access; answer is due one edge later and stands one cycle
  task automatic cpu(input logic [31:0] a, input logic w, f, v, e,
      input addr_map_pkg::target_t t, input logic [31:0] off);
    cpuReq = 1'h1;
    cpuAddr = a;
    cpuWrite = w;
    cpuFetch = f;
    cpuVector = v;
    @(posedge sys_clk);
    #1;
    chk(respValid === 1'h1 && respMaster === 1'h0 && respWrite === w, "answer");
    chk(respErr === e && respTarget === t, "target");
    chk(e || respOffset === off, "offset");
    chk(sysBusSel === (!e && t != addr_map_pkg::TGT_CORE_PRIVATE_BUS), "bus select");
    chk(corePrivateSel === (!e && t == addr_map_pkg::TGT_CORE_PRIVATE_BUS), "core select");
  endtask

  task automatic m(input logic [31:0] a, input addr_map_pkg::target_t t, input logic [31:0] o);
    cpu(a, 1'h0, 1'h0, 1'h0, 1'h0, t, o);
  endtask

  task automatic er(input logic [31:0] a, input logic f);
    cpu(a, 1'h0, f, 1'h0, 1'h1, addr_map_pkg::TGT_NONE, 32'h0);
  endtask

  task automatic idle();
    cpuReq = 1'h0;
    @(posedge sys_clk);
    #1;
    chk(respValid === 1'h0 && respTarget === addr_map_pkg::TGT_NONE, "idle");
  endtask

  // requests held during reset must be dropped
  task automatic test_reset();
    sys_rst = 1'h1;
    cpuReq = 1'h1;
    cpuAddr = 32'h2000_0000;
    repeat (16) @(posedge sys_clk);
    #1;
    chk(respValid === 1'h0 && sysBusSel === 1'h0, "reset");
    sys_rst = 1'h0;
    idle();
    $display("test reset done");
  endtask

  task automatic test_map();
    m(32'h0000_7FFC, addr_map_pkg::TGT_FLASH, 32'h0000_7FFC);
    m(32'h1000_0FFC, addr_map_pkg::TGT_SUPERVISORY_ROM, 32'h0000_0FFC);
    m(32'h2000_0FFC, addr_map_pkg::TGT_SRAM, 32'h0000_0FFC);
    m(32'h4000_0004, addr_map_pkg::TGT_CPU_SUBSYSTEM, 32'h0000_0004);
    m(32'h4001_0FFC, addr_map_pkg::TGT_IO_ROUTING_MATRIX, 32'h0000_0FFC);
    m(32'h4002_0000, addr_map_pkg::TGT_CLOCKS, 32'h0000_0000);
    m(32'h4004_0010, addr_map_pkg::TGT_IO_PORT, 32'h0000_0010);
    m(32'h4005_0020, addr_map_pkg::TGT_TIMER, 32'h0000_0020);
    m(32'h4006_0000, addr_map_pkg::TGT_SERIAL, 32'h0000_0000);
    m(32'h4008_0008, addr_map_pkg::TGT_TOUCH, 32'h0000_0008);
    m(32'h4009_0000, addr_map_pkg::TGT_LCD, 32'h0000_0000);
    m(32'h400A_FFFC, addr_map_pkg::TGT_COMPARATOR, 32'h0000_FFFC);
    m(32'h400B_FFFC, addr_map_pkg::TGT_POWER_CONTROL, 32'h0000_FFFC);
    m(32'hE00F_FFFC, addr_map_pkg::TGT_CORE_PRIVATE_BUS, 32'h000F_FFFC);
    er(32'h0000_8000, 1'h0);
    er(32'h2000_1000, 1'h0);
    er(32'h4001_1000, 1'h0);
    er(32'h6000_0000, 1'h0);
    er(32'hDFFF_FFFC, 1'h0);
    er(32'hE010_0000, 1'h0);
    idle();
    $display("test map done");
  endtask

  task automatic test_exec();
    cpu(32'h0000_0100, 1'h0, 1'h1, 1'h0, 1'h0, addr_map_pkg::TGT_FLASH, 32'h100);
    cpu(32'h2000_0040, 1'h1, 1'h0, 1'h0, 1'h0, addr_map_pkg::TGT_SRAM, 32'h40);
    cpu(32'h2000_0080, 1'h0, 1'h1, 1'h0, 1'h0, addr_map_pkg::TGT_SRAM, 32'h80);
    cpu(32'h4000_0000, 1'h0, 1'h1, 1'h0, 1'h1, addr_map_pkg::TGT_CPU_SUBSYSTEM, 32'h0);
    cpu(32'h400B_0000, 1'h0, 1'h1, 1'h0, 1'h1, addr_map_pkg::TGT_POWER_CONTROL, 32'h0);
    idle();
    $display("test exec done");
  endtask

  // only bit 0 of the config word may steer the table
  task automatic test_vector();
    cfg = 32'hFFFF_FFFE;
    cpu(32'h8, 1'h0, 1'h0, 1'h1, 1'h0, addr_map_pkg::TGT_FLASH, 32'h8);
    cfg = 32'h0000_0001;
    cpu(32'h8, 1'h0, 1'h0, 1'h1, 1'h0, addr_map_pkg::TGT_SRAM, 32'h8);
    cpu(32'h3C, 1'h0, 1'h0, 1'h1, 1'h0, addr_map_pkg::TGT_SRAM, 32'h3C);
    idle();
    cfg = 32'h0;
    $display("test vector done");
  endtask

  task automatic test_debug();
    go = 1'h1;
    goAddr = 32'h400B_0010;
    m(32'h2000_0000, addr_map_pkg::TGT_SRAM, 32'h0);
    go = 1'h0;
    chk(dbgReq === 1'h1 && dbgGnt === 1'h0 && cpuGnt === 1'h1, "debug held");
    cpuReq = 1'h0;
    #1;
    chk(dbgGnt === 1'h1, "debug grant");
    @(posedge sys_clk);
    #1;
    chk(respValid === 1'h1 && respMaster === 1'h1 && respErr === 1'h0, "debug answer");
    chk(respTarget === addr_map_pkg::TGT_POWER_CONTROL && respOffset === 32'h10, "debug map");
    idle();
    $display("test debug done");
  endtask

  initial begin
    test_reset();
    test_map();
    test_exec();
    test_vector();
    test_debug();
    test_reset();
    finish_test();
  end

  initial begin
    #400000;
    fails++;
    finish_test();
  end
endmodule
